// *** omc_params.svh ***
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH
`define OMC_MODE_SLEEP 3'h1
`define OMC_MODE_STANDBY 3'h4
`define OMC_MODE_NORMAL 3'h7
`define OMC_CLK_HZ 20000000
`define OMC_STARTUP_US 2800
`define OMC_RESET_PULSE_US 20
`define OMC_SPI_HOLDOFF_US 2
`define OMC_SILENCE_MS 1
`define OMC_US_CYCLES(us) (((us) * `OMC_CLK_HZ + 999999) / 1000000)
`endif

// *** omc_pkg.sv ***
package omc_pkg;
  typedef enum logic [6:0] {
    OMC_OFF = 7'h01,
    OMC_RESET = 7'h02,
    OMC_STANDBY = 7'h04,
    OMC_NORMAL = 7'h08,
    OMC_SLEEP = 7'h10,
    OMC_FNORMAL = 7'h20,
    OMC_OVERTEMP = 7'h40
  } omc_state_t;

  typedef struct packed {
    logic main_reg_en;
    logic aux_reg_en;
    logic spi_en;
    logic wdg_en;
    logic wdg_window_ok;
    logic can_active;
    logic temp_prot_en;
    logic bias_auto_en;
  } omc_ctrl_t;

  typedef struct packed {
    logic can_wake_enable;
    logic local_wake_enable;
    logic diag_wake_enable;
    logic partial_net_config;
    logic partial_net_config_valid;
    logic aux_supply_control;
    logic aux_supply_startup_ctrl;
    logic wdg_enable;
    logic can_active_req;
  } omc_cfg_t;
endpackage : omc_pkg

// *** omc_sync.sv ***
`timescale 1ns/1ns
module omc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : omc_sync

// *** omc_mode_ctrl.sv ***
`timescale 1ns/1ns
`include "omc_params.svh"
module omc_mode_ctrl #(
  parameter int STARTUP_CYC = `OMC_US_CYCLES(`OMC_STARTUP_US),
  parameter int SILENCE_CYC = (`OMC_SILENCE_MS * 1000 * `OMC_CLK_HZ) / 1000000,
  parameter int RST_PULSE_CYC = `OMC_US_CYCLES(`OMC_RESET_PULSE_US),
  parameter int HOLDOFF_CYC = `OMC_US_CYCLES(`OMC_SPI_HOLDOFF_US)
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_power_good,
  input wire logic i_overtemp,
  input wire logic i_overtemp_clear,
  input wire logic i_forced_normal,
  input wire logic i_sleep_lockout_bit,
  input wire omc_pkg::omc_cfg_t i_cfg,
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode_select_field,
  input wire logic i_reset_event,
  input wire logic i_reset_line_n_in,
  input wire logic i_can_rx_bit,
  input wire logic i_can_wake_pattern,
  input wire logic i_can_wake_frame,
  input wire logic i_local_wake,
  input wire logic i_diag_wake,
  input wire logic i_wake_clear,
  input wire logic i_system_failure,
  output omc_pkg::omc_state_t o_mode,
  output omc_pkg::omc_ctrl_t o_ctrl,
  output logic o_spi_accept,
  output logic o_spi_fail,
  output logic o_wake_pending,
  output logic o_receive_out_pin,
  output logic o_reset_line_n_out,
  output logic o_reset_line_n_oe,
  output logic o_limp_out,
  output logic o_limp_oe,
  output logic o_bias_mid
);
  localparam int CW = 32;

  initial begin
    if (STARTUP_CYC < 1 || SILENCE_CYC < 1 || RST_PULSE_CYC < 1 || HOLDOFF_CYC < 1) begin
      $error("omc_mode_ctrl: timing counts must be at least one cycle");
    end
  end

  logic [4:0] async_in;
  logic [4:0] sync_in;
  logic s_reset_line_n_pin;
  logic s_can_rx;
  logic s_can_rx_n;
  logic s_local_wake;
  logic s_can_pat;
  logic s_can_frm;

  // bus data is synced inverted so the synchroniser's reset value equals the recessive
  // level; otherwise the edge detector would see a false edge right after reset
  assign async_in = {i_reset_line_n_in, !i_can_rx_bit, i_local_wake, i_can_wake_pattern,
                     i_can_wake_frame};
  assign {s_reset_line_n_pin, s_can_rx_n, s_local_wake, s_can_pat, s_can_frm} = sync_in;
  assign s_can_rx = !s_can_rx_n;

  omc_sync #(.WIDTH(5)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_async(async_in),
    .o_sync(sync_in)
  );

  omc_pkg::omc_state_t state;
  omc_pkg::omc_state_t next_state;
  logic [CW-1:0] tmr;
  logic [CW-1:0] holdoff;
  logic [CW-1:0] silence;
  logic wake_latched;
  logic can_rx_d;
  logic bus_active;
  logic low_power;
  logic can_wake_hit;
  logic wake_event;
  logic mode_bad;
  logic sleep_locked;
  logic tmr_done;
  logic spi_window;

  assign low_power = (state == omc_pkg::OMC_STANDBY) || (state == omc_pkg::OMC_SLEEP)
                     || (state == omc_pkg::OMC_RESET);
  assign tmr_done = (tmr == '0);
  // selective wake only when both the configuration and its validity bit are set
  assign can_wake_hit = i_cfg.can_wake_enable && low_power &&
                        ((i_cfg.partial_net_config && i_cfg.partial_net_config_valid)
                         ? s_can_frm : s_can_pat);
  assign wake_event = can_wake_hit || (i_cfg.local_wake_enable && s_local_wake && low_power)
                      || (i_cfg.diag_wake_enable && i_diag_wake);
  assign spi_window = (state == omc_pkg::OMC_STANDBY || state == omc_pkg::OMC_NORMAL ||
                       state == omc_pkg::OMC_FNORMAL) && (holdoff == '0);
  assign mode_bad = (i_mode_select_field != `OMC_MODE_SLEEP) &&
                    (i_mode_select_field != `OMC_MODE_STANDBY) &&
                    (i_mode_select_field != `OMC_MODE_NORMAL);
  // lockout is a strap from non-volatile storage; it is only read, never written here
  assign sleep_locked = i_sleep_lockout_bit &&
                        (i_mode_select_field == `OMC_MODE_SLEEP);

  always_comb begin
    next_state = state;
    unique case (state)
      omc_pkg::OMC_OFF: begin
        if (i_power_good && tmr_done) begin
          next_state = omc_pkg::OMC_RESET;
        end
      end
      omc_pkg::OMC_RESET: begin
        if (i_overtemp) begin
          next_state = omc_pkg::OMC_OVERTEMP;
        end else if (tmr_done && s_reset_line_n_pin) begin
          next_state = i_forced_normal ? omc_pkg::OMC_FNORMAL : omc_pkg::OMC_STANDBY;
        end
      end
      omc_pkg::OMC_STANDBY, omc_pkg::OMC_NORMAL: begin
        if (i_overtemp) begin
          next_state = omc_pkg::OMC_OVERTEMP;
        end else if (i_reset_event || !s_reset_line_n_pin) begin
          next_state = omc_pkg::OMC_RESET;
        end else if (i_mode_wr && spi_window && !mode_bad && !sleep_locked) begin
          unique case (i_mode_select_field)
            `OMC_MODE_SLEEP: next_state = omc_pkg::OMC_SLEEP;
            `OMC_MODE_STANDBY: next_state = omc_pkg::OMC_STANDBY;
            default: next_state = omc_pkg::OMC_NORMAL;
          endcase
        end
      end
      omc_pkg::OMC_SLEEP: begin
        // temperature protection is off here, so overtemp is not tracked
        if (wake_event) begin
          next_state = omc_pkg::OMC_RESET;
        end
      end
      omc_pkg::OMC_FNORMAL: begin
        if (i_overtemp) begin
          next_state = omc_pkg::OMC_OVERTEMP;
        end else if (i_reset_event || !s_reset_line_n_pin) begin
          next_state = omc_pkg::OMC_RESET;
        end
      end
      omc_pkg::OMC_OVERTEMP: begin
        if (i_overtemp_clear) begin
          next_state = omc_pkg::OMC_RESET;
        end
      end
      default: next_state = omc_pkg::OMC_OFF;
    endcase
    if (!i_power_good) begin
      next_state = omc_pkg::OMC_OFF;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= omc_pkg::OMC_OFF;
    end else begin
      state <= next_state;
    end
  end

  // one timer serves startup delay and the reset pulse
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tmr <= CW'(STARTUP_CYC);
    end else if (next_state != state) begin
      if (next_state == omc_pkg::OMC_RESET) begin
        tmr <= CW'(RST_PULSE_CYC - 1);
      end else if (next_state == omc_pkg::OMC_OFF) begin
        tmr <= CW'(STARTUP_CYC - 1);
      end else begin
        tmr <= '0;
      end
    end else if (state == omc_pkg::OMC_OFF && !i_power_good) begin
      tmr <= CW'(STARTUP_CYC - 1);
    end else if (!tmr_done) begin
      tmr <= tmr - CW'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      holdoff <= '0;
    end else if (state == omc_pkg::OMC_RESET && next_state != omc_pkg::OMC_RESET) begin
      holdoff <= CW'(HOLDOFF_CYC);
    end else if (holdoff != '0) begin
      holdoff <= holdoff - CW'(1);
    end
  end

  // set wins over clear so a wake arriving with the clear is kept
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wake_latched <= 1'b0;
    end else if (wake_event) begin
      wake_latched <= 1'b1;
    end else if (i_wake_clear && spi_window) begin
      wake_latched <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      can_rx_d <= 1'b1;
      silence <= '0;
      bus_active <= 1'b0;
    end else begin
      can_rx_d <= s_can_rx;
      if (s_can_rx != can_rx_d) begin
        silence <= '0;
        bus_active <= 1'b1;
      end else if (silence >= CW'(SILENCE_CYC)) begin
        bus_active <= 1'b0;
      end else begin
        silence <= silence + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mode <= omc_pkg::OMC_OFF;
      o_ctrl <= '0;
      o_bias_mid <= 1'b0;
    end else begin
      o_mode <= state;
      o_ctrl.main_reg_en <= state inside {omc_pkg::OMC_NORMAL, omc_pkg::OMC_STANDBY,
                                          omc_pkg::OMC_RESET, omc_pkg::OMC_FNORMAL};
      o_ctrl.aux_reg_en <= (state == omc_pkg::OMC_FNORMAL) ||
                           ((state inside {omc_pkg::OMC_NORMAL, omc_pkg::OMC_STANDBY,
                                           omc_pkg::OMC_SLEEP}) && i_cfg.aux_supply_control) ||
                           (state == omc_pkg::OMC_RESET &&
                            (i_cfg.aux_supply_control || i_cfg.aux_supply_startup_ctrl));
      o_ctrl.spi_en <= state inside {omc_pkg::OMC_NORMAL, omc_pkg::OMC_STANDBY,
                                     omc_pkg::OMC_FNORMAL};
      o_ctrl.wdg_en <= i_cfg.wdg_enable &&
                       (state inside {omc_pkg::OMC_NORMAL, omc_pkg::OMC_STANDBY});
      o_ctrl.wdg_window_ok <= (state == omc_pkg::OMC_NORMAL);
      o_ctrl.can_active <= (state == omc_pkg::OMC_FNORMAL) ||
                           (state == omc_pkg::OMC_NORMAL && i_cfg.can_active_req);
      o_ctrl.temp_prot_en <= !(state inside {omc_pkg::OMC_SLEEP, omc_pkg::OMC_OFF});
      o_ctrl.bias_auto_en <= state inside {omc_pkg::OMC_STANDBY, omc_pkg::OMC_SLEEP,
                                           omc_pkg::OMC_RESET, omc_pkg::OMC_NORMAL};
      o_bias_mid <= bus_active && (state != omc_pkg::OMC_OFF) &&
                    (state != omc_pkg::OMC_OVERTEMP);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_spi_accept <= 1'b0;
      o_spi_fail <= 1'b0;
    end else begin
      o_spi_accept <= spi_window;
      o_spi_fail <= i_mode_wr && spi_window && (mode_bad || sleep_locked);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake_pending <= 1'b0;
      o_receive_out_pin <= 1'b1;
    end else begin
      o_wake_pending <= wake_latched || wake_event;
      if (state == omc_pkg::OMC_FNORMAL ||
          (state == omc_pkg::OMC_NORMAL && i_cfg.can_active_req)) begin
        o_receive_out_pin <= s_can_rx;
      end else begin
        o_receive_out_pin <= !(wake_latched || wake_event);
      end
    end
  end

  // open-drain style pins: output value is always low, the enable pulls
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reset_line_n_out <= 1'b0;
      o_reset_line_n_oe <= 1'b1;
      o_limp_out <= 1'b0;
      o_limp_oe <= 1'b0;
    end else begin
      o_reset_line_n_out <= 1'b0;
      // the pulse is released when the timer ends, so an external hold can be seen
      o_reset_line_n_oe <= (state inside {omc_pkg::OMC_OFF, omc_pkg::OMC_SLEEP,
                                          omc_pkg::OMC_OVERTEMP}) ||
                           (state == omc_pkg::OMC_RESET && !tmr_done);
      o_limp_out <= 1'b0;
      o_limp_oe <= i_system_failure;
    end
  end
endmodule : omc_mode_ctrl

// *** omc_mode_ctrl_assertions.sv ***
`timescale 1ns/1ns
module omc_mode_ctrl_assertions (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire omc_pkg::omc_cfg_t i_cfg,
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode_select_field,
  input wire logic i_sleep_lockout_bit,
  input wire logic i_diag_wake,
  input wire logic i_system_failure,
  input wire omc_pkg::omc_state_t o_mode,
  input wire omc_pkg::omc_ctrl_t o_ctrl,
  input wire logic o_spi_accept,
  input wire logic o_spi_fail,
  input wire logic o_wake_pending,
  input wire logic o_receive_out_pin,
  input wire logic o_reset_line_n_oe,
  input wire logic o_limp_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic wr_ok;
  // only counts writes made while the mode has settled in an spi-active state
  assign wr_ok = i_mode_wr && o_spi_accept &&
    (o_mode == omc_pkg::OMC_NORMAL || o_mode == omc_pkg::OMC_STANDBY);
  sequence fail_kept_s;
    o_spi_fail ##1 $stable(o_mode);
  endsequence
  bad_code_a: assert property (wr_ok && !(i_mode_select_field inside {3'h1, 3'h4, 3'h7})
    |=> fail_kept_s) else $error("undefined mode code not flagged");
  sleep_lock_a: assert property (wr_ok && i_mode_select_field == 3'h1 && i_sleep_lockout_bit
    |=> fail_kept_s) else $error("locked sleep request not flagged");
  normal_entry_a: assert property (wr_ok && i_mode_select_field == 3'h7
    |-> ##2 o_mode == omc_pkg::OMC_NORMAL) else $error("code 111 did not give normal");
  standby_entry_a: assert property (wr_ok && i_mode_select_field == 3'h4
    |-> ##2 o_mode == omc_pkg::OMC_STANDBY) else $error("code 100 did not give standby");
  sleep_entry_a: assert property (wr_ok && i_mode_select_field == 3'h1 && !i_sleep_lockout_bit
    |-> ##2 o_mode == omc_pkg::OMC_SLEEP) else $error("code 001 did not give sleep");
  standby_ctrl_a: assert property (o_mode == omc_pkg::OMC_STANDBY |-> !o_ctrl.can_active &&
    o_ctrl.spi_en && o_ctrl.main_reg_en && !o_ctrl.wdg_window_ok)
    else $error("standby controls wrong");
  sleep_ctrl_a: assert property (o_mode == omc_pkg::OMC_SLEEP |-> !o_ctrl.main_reg_en &&
    !o_ctrl.spi_en && !o_ctrl.wdg_en && !o_ctrl.temp_prot_en && o_ctrl.bias_auto_en)
    else $error("sleep controls wrong");
  reset_ctrl_a: assert property (o_mode == omc_pkg::OMC_RESET |->
    !o_ctrl.spi_en && !o_ctrl.wdg_en && o_ctrl.main_reg_en)
    else $error("reset mode controls wrong");
  reset_pulse_a: assert property ($rose(o_mode == omc_pkg::OMC_RESET) |-> o_reset_line_n_oe)
    else $error("reset line not pulled on reset entry");
  wake_rx_a: assert property ((o_wake_pending && !(o_mode inside {omc_pkg::OMC_NORMAL,
    omc_pkg::OMC_FNORMAL})) [*2] |-> !o_receive_out_pin)
    else $error("pending wake not shown on receive pin");
  sleep_exit_a: assert property (o_mode == omc_pkg::OMC_SLEEP && i_diag_wake &&
    i_cfg.diag_wake_enable |-> ##[1:4] o_mode == omc_pkg::OMC_RESET)
    else $error("wake did not leave sleep");
  limp_a: assert property (i_system_failure |-> ##[1:3] o_limp_oe)
    else $error("limp output not asserted");
endmodule : omc_mode_ctrl_assertions

bind omc_mode_ctrl omc_mode_ctrl_assertions u_chk (.*);

// *** omc_host_model.sv ***
`timescale 1ns/1ns
module omc_host_model #(
  parameter int HOLD = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_dev_oe,
  input wire logic i_pull,
  output logic o_line,
  output logic o_spi_ok
);
  int cnt = HOLD;
  // both parties only sink current; the board pull-up sets the released level
  assign o_line = !(i_dev_oe || i_pull);
  // host keeps off the spi for the holdoff after the line rises
  always_ff @(posedge i_clk_sys) cnt <= o_line ? ((cnt > 0) ? cnt - 1 : 0) : HOLD;
  assign o_spi_ok = o_line && cnt == 0;
endmodule : omc_host_model

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, pg = 1'b1, ot = 1'b0, ot_clr = 1'b0, fnorm = 1'b0;
  logic lock = 1'b0, wr = 1'b0, rst_ev = 1'b0, rx = 1'b1, wpat = 1'b0, wfrm = 1'b0;
  logic lwake = 1'b0, dwake = 1'b0, wclr = 1'b0, sfail = 1'b0, pull = 1'b0;
  logic line, spi_ok, o_spi_accept, o_spi_fail, o_wake_pending, o_receive_out_pin, oe, limp;
  logic [2:0] sel = 3'h0;
  omc_pkg::omc_cfg_t cfg = 9'h149;
  omc_pkg::omc_state_t o_mode;
  omc_pkg::omc_ctrl_t o_ctrl;
  int n_fail = 0, num_checks = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  omc_mode_ctrl #(.STARTUP_CYC(8), .SILENCE_CYC(16), .RST_PULSE_CYC(4), .HOLDOFF_CYC(3)) uut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_power_good(pg), .i_overtemp(ot),
    .i_overtemp_clear(ot_clr), .i_forced_normal(fnorm), .i_sleep_lockout_bit(lock),
    .i_cfg(cfg), .i_mode_wr(wr), .i_mode_select_field(sel), .i_reset_event(rst_ev),
    .i_reset_line_n_in(line), .i_can_rx_bit(rx), .i_can_wake_pattern(wpat),
    .i_can_wake_frame(wfrm), .i_local_wake(lwake), .i_diag_wake(dwake), .i_wake_clear(wclr),
    .i_system_failure(sfail), .o_mode(o_mode), .o_ctrl(o_ctrl), .o_spi_accept(o_spi_accept),
    .o_spi_fail(o_spi_fail), .o_wake_pending(o_wake_pending),
    .o_receive_out_pin(o_receive_out_pin), .o_reset_line_n_out(), .o_reset_line_n_oe(oe),
    .o_limp_out(), .o_limp_oe(limp), .o_bias_mid());
  omc_host_model #(.HOLD(3)) u_host (.i_clk_sys(i_clk_sys), .i_dev_oe(oe), .i_pull(pull),
    .o_line(line), .o_spi_ok(spi_ok));

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wait_mode(input omc_pkg::omc_state_t m);
    int k;
    k = 0;
    while (o_mode !== m && k < 200) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    check("mode", {1'b0, o_mode}, {1'b0, m});
  endtask : wait_mode

  task wait_spi;
    int k;
    k = 0;
    while (!(o_spi_accept === 1'b1 && spi_ok === 1'b1) && k < 50) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    check("spi_accept", {7'h0, o_spi_accept}, 8'h1);
  endtask : wait_spi

  task write_mode(input logic [2:0] c, input logic fail);
    @(posedge i_clk_sys);
    wr <= 1'b1;
    sel <= c;
    @(posedge i_clk_sys);
    wr <= 1'b0;
    #1;
    check("spi_fail", {7'h0, o_spi_fail}, {7'h0, fail});
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    #1;
  endtask : write_mode

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    wait_mode(omc_pkg::OMC_STANDBY);
    wait_spi();
    check("standby ctrl", {4'h0, o_ctrl.main_reg_en, o_ctrl.aux_reg_en, o_ctrl.spi_en,
      o_ctrl.can_active}, 8'he);
    $display("test power-up done");
    write_mode(3'h7, 1'b0);
    check("normal mode", {1'b0, o_mode}, 8'h08);
    check("normal ctrl", {6'h0, o_ctrl.main_reg_en, o_ctrl.can_active}, 8'h3);
    for (int c = 0; c < 8; c++) begin
      if (!(c inside {1, 4, 7})) begin
        write_mode(c[2:0], 1'b1);
        check("kept mode", {1'b0, o_mode}, 8'h08);
      end
    end
    lock <= 1'b1;
    write_mode(3'h1, 1'b1);
    check("locked sleep", {1'b0, o_mode}, 8'h08);
    lock <= 1'b0;
    write_mode(3'h4, 1'b0);
    check("standby mode", {1'b0, o_mode}, 8'h04);
    write_mode(3'h1, 1'b0);
    check("sleep ctrl", {1'b0, o_mode[4], o_ctrl.main_reg_en, o_ctrl.spi_en, o_ctrl.wdg_en,
      o_ctrl.bias_auto_en, oe, o_spi_accept}, 8'h46);
    write_mode(3'h7, 1'b0);
    check("write ignored", {1'b0, o_mode}, 8'h10);
    $display("test mode writes done");
    @(posedge i_clk_sys);
    dwake <= 1'b1;
    @(posedge i_clk_sys);
    dwake <= 1'b0;
    wait_mode(omc_pkg::OMC_RESET);
    check("reset pin", {5'h0, oe, o_wake_pending, o_receive_out_pin}, 8'h6);
    wait_mode(omc_pkg::OMC_STANDBY);
    wait_spi();
    @(posedge i_clk_sys);
    wclr <= 1'b1;
    @(posedge i_clk_sys);
    wclr <= 1'b0;
    lwake <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    lwake <= 1'b0;
    #1;
    check("wake latch", {6'h0, o_wake_pending, o_receive_out_pin}, 8'h1);
    $display("test wake done");
    sfail <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1;
    check("limp", {7'h0, limp}, 8'h1);
    sfail <= 1'b0;
    pull <= 1'b1;
    wait_mode(omc_pkg::OMC_RESET);
    pull <= 1'b0;
    wait_mode(omc_pkg::OMC_STANDBY);
    $display("test external reset done");
    print_verdict();
  end

  initial begin
    #(5000 * 50);
    n_fail++;
    print_verdict();
  end
endmodule : testbench
